// [cwgsd_db_if.sv]
// carrier between the top and one dead-band timer
`timescale 1ns/10ps
interface cwgsd_db_if;
    import cwgsd_pkg::*;
    logic lvl;
    logic [DB_W-1:0] count;
    logic active;
    modport timer (input lvl, input count, output active);
    modport user (output lvl, output count, input active);
endinterface : cwgsd_db_if

// [cwgsd_deadband.sv]
// dead-band timer: active rises count clock periods after level rises, falls with level
`timescale 1ns/10ps
module cwgsd_deadband (
    input wire logic clk,
    input wire logic rst_n,
    cwgsd_db_if.timer db
);
    import cwgsd_pkg::*;

    typedef struct packed {
        logic prev;
        logic [DB_W-1:0] cnt;
    } cwgsd_dbst_s;

    cwgsd_dbst_s st_r;
    cwgsd_dbst_s st_nxt;

    // ----------------------------------------------------------------
    // count down from the level's rising edge
    // ----------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.prev = db.lvl;
        if (db.lvl && !st_r.prev) begin
            st_nxt.cnt = (db.count == '0) ? '0 : db.count - 1'b1;
        end else if (db.lvl && st_r.cnt != '0) begin
            st_nxt.cnt = st_r.cnt - 1'b1;
        end else if (!db.lvl) begin
            st_nxt.cnt = '0;
        end
    end

    // zero count passes straight through
    assign db.active = db.lvl && (st_r.prev ? st_r.cnt == '0 : db.count == '0);

    always_ff @(posedge clk or negedge rst_n) begin
        // prev starts high so an idle-high level gives no false edge after reset
        if (!rst_n) begin
            st_r <= '{prev: 1'b1, cnt: '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    chk_rise_delay: assert property (@(posedge clk) disable iff (!rst_n)
        ($rose(db.lvl) && db.count == 6'h03 ##1 db.lvl [*3])
        |-> db.active && !$past(db.active))
        else $error("dead-band delay differs from count");

    chk_zero_bypass: assert property (@(posedge clk) disable iff (!rst_n)
        (db.lvl && !st_r.prev && db.count == 6'h00) |-> db.active)
        else $error("zero count did not bypass");

endmodule : cwgsd_deadband

// [cwgsd_edge.sv]
// edge detector for the generator data input
`timescale 1ns/10ps
module cwgsd_edge (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic d,
    output logic rise,
    output logic fall
);
    typedef struct packed {
        logic prev;
    } cwgsd_edst_s;

    cwgsd_edst_s st_r;
    cwgsd_edst_s st_nxt;

    // remember last level
    always_comb begin
        st_nxt = st_r;
        st_nxt.prev = d;
    end

    assign rise = d && !st_r.prev;
    assign fall = !d && st_r.prev;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

endmodule : cwgsd_edge

// [cwgsd_gate_model.sv]
// gate-driver model standing on the four output pins
`timescale 1ns/10ps
module cwgsd_gate_model (
    input wire logic [3:0] drive,
    input wire logic [3:0] oe_n,
    output logic [3:0] gate
);
    // ----------------------------------------------------------------
    // pin resolution
    // ----------------------------------------------------------------
    // an undriven gate input is held low by the driver's pull-down
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            gate[i] = oe_n[i] ? 1'b0 : drive[i];
        end
    end
endmodule : cwgsd_gate_model

// [cwgsd_pkg.sv]
// constants, types and register map of the shutdown and dead-band block
// Overview of operation
// - status bit shows shutdown in effect, set by hardware
// - auto-restart bit clears status once cause gone
// - b/d pins follow their shutdown state field
// - a/c pins follow their shutdown state field
// - software may set status to force shutdown
// - after clear, hold shutdown until data rises
// - eight independent shutdown source enable bits
// - source zero is the selected shutdown pin
// - rising dead-band delays output by count periods
// - falling dead-band delays complement by count periods
// - zero count bypasses the dead-band delay
// - dead-band counts have no reset value
// - load bit updates buffers on rise after fall
// - per-output polarity bit inverts and sets inactive
package cwgsd_pkg;

    // ----------------------------------------------------------------
    // register indices; byte address is four times the index
    // ----------------------------------------------------------------
    localparam logic [11:0] RIDX_DB_RISE = 12'h3be;
    localparam logic [11:0] RIDX_DB_FALL = 12'h3bf;
    localparam logic [11:0] RIDX_GEN_CTRL = 12'h3c0;
    localparam logic [11:0] RIDX_POL_CTRL = 12'h3c1;
    localparam logic [11:0] RIDX_SD_CTRL = 12'h3c2;
    localparam logic [11:0] RIDX_SD_SRC = 12'h3c3;

    // ----------------------------------------------------------------
    // field positions and reset values
    // ----------------------------------------------------------------
    localparam int DB_W = 6;
    localparam int GEN_EN_BIT = 7;
    localparam int GEN_LD_BIT = 6;
    localparam int POL_IN_BIT = 5;
    localparam int SD_STAT_BIT = 7;
    localparam int SD_REN_BIT = 6;
    localparam int SD_BD_LO = 4;
    localparam int SD_AC_LO = 2;
    localparam logic [7:0] SD_CTRL_RST = 8'h14;
    localparam logic [7:0] SD_SRC_RST = 8'h00;
    localparam logic [3:0] POL_RST = 4'h0;

    // ----------------------------------------------------------------
    // shutdown state codes of a pin pair
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        SDST_INACTIVE = 2'b00,
        SDST_TRISTATE = 2'b01,
        SDST_LOW = 2'b10,
        SDST_HIGH = 2'b11
    } cwgsd_sdst_e;

endpackage : cwgsd_pkg

// [cwgsd_top.sv]
// auto-shutdown and dead-band block with wishbone register slave
//
// The Wishbone interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
module cwgsd_top (
    input wire logic CLOCK,
    input wire logic RSTN,
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic WE_I,
    input wire logic [13:0] ADR_I,
    input wire logic [3:0] SEL_I,
    input wire logic [31:0] DAT_I,
    output logic [31:0] DAT_O,
    output logic ACK_O,
    input wire logic DATA_IN,
    input wire logic [7:0] SHUTDOWN_SRC,
    output logic OUT_A,
    output logic OUT_B,
    output logic OUT_C,
    output logic OUT_D,
    output logic OUT_A_OE_N,
    output logic OUT_B_OE_N,
    output logic OUT_C_OE_N,
    output logic OUT_D_OE_N
);
    import cwgsd_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic ack;
        logic [7:0] rdat;
        logic en;
        logic ld;
        logic ld_fall;
        logic [3:0] pol;
        logic sd;
        logic ren;
        cwgsd_sdst_e bd;
        cwgsd_sdst_e ac;
        logic [7:0] srcen;
        logic hold;
        logic [3:0] out;
        logic [3:0] oe_n;
    } cwgsd_st_s;

    // counts and their working buffers carry no reset
    typedef struct packed {
        logic [DB_W-1:0] rising_deadband_count;
        logic [DB_W-1:0] dbf;
        logic [DB_W-1:0] bufr;
        logic [DB_W-1:0] buff;
    } cwgsd_cnt_s;

    cwgsd_st_s s_r;
    cwgsd_st_s s_nxt;
    cwgsd_cnt_s c_r;
    cwgsd_cnt_s c_nxt;

    logic req;
    logic wr_commit;
    logic [11:0] widx;
    logic sd_event;
    logic rise;
    logic fall;
    logic load_buf;

    // ----------------------------------------------------------------
    // pin drive for one output
    // ----------------------------------------------------------------
    // returns {oe_n, value}
    function automatic logic [1:0] pin_drive(input logic hold, input logic en,
                                             input cwgsd_sdst_e st, input logic act,
                                             input logic pol);
        logic [1:0] r;
        r = 2'b10;
        if (hold) begin
            unique case (st)
                SDST_HIGH: r = 2'b01;
                SDST_LOW: r = 2'b00;
                SDST_TRISTATE: r = 2'b10;
                SDST_INACTIVE: r = {1'b0, pol};
            endcase
        end else if (en) begin
            r = {1'b0, act ^ pol};
        end
        return r;
    endfunction : pin_drive

    // ----------------------------------------------------------------
    // helpers: edges, dead-band timers, bus decode
    // ----------------------------------------------------------------
    cwgsd_db_if rise_if ();
    cwgsd_db_if fall_if ();

    cwgsd_edge u_edge (
        .clk(CLOCK),
        .rst_n(RSTN),
        .d(DATA_IN),
        .rise(rise),
        .fall(fall)
    );

    // rising timer delays a/c, falling timer delays b/d
    assign rise_if.lvl = DATA_IN;
    // a loading edge already times with the newly loaded count
    assign rise_if.count = load_buf ? c_r.rising_deadband_count : c_r.bufr;
    assign fall_if.lvl = !DATA_IN;
    assign fall_if.count = load_buf ? c_r.dbf : c_r.buff;

    cwgsd_deadband u_db_rise (
        .clk(CLOCK),
        .rst_n(RSTN),
        .db(rise_if.timer)
    );

    cwgsd_deadband u_db_fall (
        .clk(CLOCK),
        .rst_n(RSTN),
        .db(fall_if.timer)
    );

    // write takes effect at the edge where the master sees ack
    assign req = CYC_I && STB_I;
    assign wr_commit = req && WE_I && s_r.ack && SEL_I[0];
    assign widx = ADR_I[13:2];

    // source 0 is the pin routed in by the pin selection
    assign sd_event = |(SHUTDOWN_SRC & s_r.srcen);

    // buffers reload on the rise that follows a fall after load request
    assign load_buf = !s_r.en || (s_r.ld_fall && rise);

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        logic [1:0] d;
        d = 2'b00;
        s_nxt = s_r;
        c_nxt = c_r;

        // bus answer: one ack per request, dropped the next cycle
        s_nxt.ack = req && !s_r.ack;
        if (req && !s_r.ack) begin
            unique case (widx)
                RIDX_DB_RISE: s_nxt.rdat = {2'b00, c_r.rising_deadband_count};
                RIDX_DB_FALL: s_nxt.rdat = {2'b00, c_r.dbf};
                RIDX_GEN_CTRL: s_nxt.rdat = {s_r.en, s_r.ld, 6'h00};
                RIDX_POL_CTRL: s_nxt.rdat = {2'b00, DATA_IN, 1'b0, s_r.pol};
                RIDX_SD_CTRL: s_nxt.rdat = {s_r.sd, s_r.ren, s_r.bd, s_r.ac, 2'b00};
                RIDX_SD_SRC: s_nxt.rdat = s_r.srcen;
                default: s_nxt.rdat = 8'h00;
            endcase
        end

        // register writes
        if (wr_commit) begin
            unique case (widx)
                RIDX_DB_RISE: c_nxt.rising_deadband_count = DAT_I[DB_W-1:0];
                RIDX_DB_FALL: c_nxt.dbf = DAT_I[DB_W-1:0];
                RIDX_GEN_CTRL: begin
                    s_nxt.en = DAT_I[GEN_EN_BIT];
                    // load request only counts once enabled
                    if (s_r.en && DAT_I[GEN_LD_BIT]) begin
                        s_nxt.ld = 1'b1;
                    end
                end
                RIDX_POL_CTRL: s_nxt.pol = DAT_I[3:0];
                RIDX_SD_CTRL: begin
                    s_nxt.ren = DAT_I[SD_REN_BIT];
                    s_nxt.bd = cwgsd_sdst_e'(DAT_I[SD_BD_LO+1:SD_BD_LO]);
                    s_nxt.ac = cwgsd_sdst_e'(DAT_I[SD_AC_LO+1:SD_AC_LO]);
                end
                RIDX_SD_SRC: s_nxt.srcen = DAT_I[7:0];
                default: s_nxt.en = s_r.en;
            endcase
        end

        // shutdown status: hardware set beats software clear
        if (sd_event) begin
            s_nxt.sd = 1'b1;
        end else if (wr_commit && widx == RIDX_SD_CTRL) begin
            s_nxt.sd = DAT_I[SD_STAT_BIT];
        end else if (s_r.ren) begin
            s_nxt.sd = 1'b0;
        end

        // outputs stay shut until the data input rises with status clear
        s_nxt.hold = s_nxt.sd || (s_r.hold && !(rise && !s_r.sd));

        // load sequencing: wait for a fall, then a rise
        if (!s_nxt.en) begin
            s_nxt.ld = 1'b0;
            s_nxt.ld_fall = 1'b0;
        end else if (s_r.ld && s_r.ld_fall && rise) begin
            s_nxt.ld = 1'b0;
            s_nxt.ld_fall = 1'b0;
        end else if (s_r.ld && fall) begin
            s_nxt.ld_fall = 1'b1;
        end
        if (load_buf) begin
            c_nxt.bufr = c_r.rising_deadband_count;
            c_nxt.buff = c_r.dbf;
        end

        // pin drive: a and c from rising timer, b and d from falling
        d = pin_drive(s_nxt.hold, s_nxt.en, s_nxt.ac, rise_if.active, s_nxt.pol[0]);
        {s_nxt.oe_n[0], s_nxt.out[0]} = d;
        d = pin_drive(s_nxt.hold, s_nxt.en, s_nxt.bd, fall_if.active, s_nxt.pol[1]);
        {s_nxt.oe_n[1], s_nxt.out[1]} = d;
        d = pin_drive(s_nxt.hold, s_nxt.en, s_nxt.ac, rise_if.active, s_nxt.pol[2]);
        {s_nxt.oe_n[2], s_nxt.out[2]} = d;
        d = pin_drive(s_nxt.hold, s_nxt.en, s_nxt.bd, fall_if.active, s_nxt.pol[3]);
        {s_nxt.oe_n[3], s_nxt.out[3]} = d;
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    // control state with asynchronous reset
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            s_r <= '{ack: 1'b0, rdat: 8'h00, en: 1'b0, ld: 1'b0, ld_fall: 1'b0,
                     pol: POL_RST, sd: SD_CTRL_RST[SD_STAT_BIT],
                     ren: SD_CTRL_RST[SD_REN_BIT],
                     bd: cwgsd_sdst_e'(SD_CTRL_RST[SD_BD_LO+1:SD_BD_LO]),
                     ac: cwgsd_sdst_e'(SD_CTRL_RST[SD_AC_LO+1:SD_AC_LO]),
                     srcen: SD_SRC_RST, hold: 1'b0, out: 4'h0, oe_n: 4'hf};
        end else begin
            s_r <= s_nxt;
        end
    end

    // counts survive every reset this block sees
    always_ff @(posedge CLOCK) begin
        c_r <= c_nxt;
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign DAT_O = {24'h000000, s_r.rdat};
    assign ACK_O = s_r.ack;
    assign OUT_A = s_r.out[0];
    assign OUT_B = s_r.out[1];
    assign OUT_C = s_r.out[2];
    assign OUT_D = s_r.out[3];
    assign OUT_A_OE_N = s_r.oe_n[0];
    assign OUT_B_OE_N = s_r.oe_n[1];
    assign OUT_C_OE_N = s_r.oe_n[2];
    assign OUT_D_OE_N = s_r.oe_n[3];

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    chk_status_set_event: assert property (@(posedge CLOCK) disable iff (!RSTN)
        sd_event |=> s_r.sd && s_r.hold)
        else $error("enabled source did not set shutdown status");

    chk_no_auto_restart: assert property (@(posedge CLOCK) disable iff (!RSTN)
        (s_r.sd && !s_r.ren && !(wr_commit && widx == RIDX_SD_CTRL)) |=> s_r.sd)
        else $error("status cleared without auto-restart");

    chk_auto_restart: assert property (@(posedge CLOCK) disable iff (!RSTN)
        (s_r.sd && s_r.ren && !sd_event && !wr_commit) |=> !s_r.sd)
        else $error("auto-restart did not clear status");

    chk_bd_state_high: assert property (@(posedge CLOCK) disable iff (!RSTN)
        (s_r.hold && s_r.bd == SDST_HIGH) |-> OUT_B && OUT_D && !OUT_B_OE_N && !OUT_D_OE_N)
        else $error("b/d not high in shutdown");

    chk_bd_state_low: assert property (@(posedge CLOCK) disable iff (!RSTN)
        (s_r.hold && s_r.bd == SDST_LOW) |-> !OUT_B && !OUT_D && !OUT_B_OE_N && !OUT_D_OE_N)
        else $error("b/d not low in shutdown");

    chk_bd_state_tri: assert property (@(posedge CLOCK) disable iff (!RSTN)
        (s_r.hold && s_r.bd == SDST_TRISTATE) |-> OUT_B_OE_N && OUT_D_OE_N)
        else $error("b/d driven in tri-state shutdown");

    chk_bd_state_inact: assert property (@(posedge CLOCK) disable iff (!RSTN)
        (s_r.hold && s_r.bd == SDST_INACTIVE) |-> OUT_D == s_r.pol[3] && !OUT_D_OE_N)
        else $error("d not at inactive level");

    chk_ac_state_high: assert property (@(posedge CLOCK) disable iff (!RSTN)
        (s_r.hold && s_r.ac == SDST_HIGH) |-> OUT_A && OUT_C && !OUT_A_OE_N && !OUT_C_OE_N)
        else $error("a/c not high in shutdown");

    chk_ac_state_low: assert property (@(posedge CLOCK) disable iff (!RSTN)
        (s_r.hold && s_r.ac == SDST_LOW) |-> !OUT_A && !OUT_C && !OUT_A_OE_N && !OUT_C_OE_N)
        else $error("a/c not low in shutdown");

    chk_ac_state_tri: assert property (@(posedge CLOCK) disable iff (!RSTN)
        (s_r.hold && s_r.ac == SDST_TRISTATE) |-> OUT_A_OE_N && OUT_C_OE_N)
        else $error("a/c driven in tri-state shutdown");

    chk_ac_state_inact: assert property (@(posedge CLOCK) disable iff (!RSTN)
        (s_r.hold && s_r.ac == SDST_INACTIVE) |-> OUT_A == s_r.pol[0] && !OUT_A_OE_N)
        else $error("a not at inactive level");

    chk_sw_force: assert property (@(posedge CLOCK) disable iff (!RSTN)
        (wr_commit && widx == RIDX_SD_CTRL && DAT_I[SD_STAT_BIT]) |=> s_r.sd ##0 s_r.hold)
        else $error("software set did not force shutdown");

    chk_idle_undriven: assert property (@(posedge CLOCK) disable iff (!RSTN)
        (!s_r.hold && !s_r.en) |-> OUT_A_OE_N && OUT_B_OE_N && OUT_C_OE_N && OUT_D_OE_N)
        else $error("pins driven while disabled and not shut down");

    chk_hold_to_rise: assert property (@(posedge CLOCK) disable iff (!RSTN)
        (s_r.hold && !rise) |=> s_r.hold)
        else $error("shutdown left before data rising edge");

    chk_masked_source: assert property (@(posedge CLOCK) disable iff (!RSTN)
        (!s_r.sd && !sd_event && !(wr_commit && widx == RIDX_SD_CTRL)) |=> !s_r.sd)
        else $error("status set without an enabled source");

    chk_buf_steady: assert property (@(posedge CLOCK) disable iff (!RSTN)
        (s_r.en && !(s_r.ld_fall && rise)) |=> $stable(c_r.bufr) && $stable(c_r.buff))
        else $error("dead-band buffer changed without load");

    chk_load_done: assert property (@(posedge CLOCK) disable iff (!RSTN)
        (s_r.en && s_r.ld && s_r.ld_fall && rise) |=> !s_r.ld && c_r.bufr == $past(c_r.rising_deadband_count))
        else $error("load edge did not refresh the rising buffer");

    chk_ld_needs_en: assert property (@(posedge CLOCK) disable iff (!RSTN)
        (wr_commit && widx == RIDX_GEN_CTRL && !s_r.en) |=> !s_r.ld)
        else $error("load request taken while disabled");

    chk_ack_answer: assert property (@(posedge CLOCK) disable iff (!RSTN)
        (req && !s_r.ack) |=> ACK_O)
        else $error("request not acknowledged in one cycle");

    chk_ack_one: assert property (@(posedge CLOCK) disable iff (!RSTN)
        ACK_O |=> !ACK_O)
        else $error("ack held longer than one cycle");

endmodule : cwgsd_top

// [tb.sv]
// testbench: register access, dead-band timing and shutdown of the block
`timescale 1ns/10ps
module tb;
    import cwgsd_pkg::*;
    logic CLOCK = 1'b0;
    logic RSTN = 1'b0;
    logic CYC_I = 1'b0;
    logic STB_I = 1'b0;
    logic WE_I = 1'b0;
    logic [13:0] ADR_I = 14'h0000;
    logic [3:0] SEL_I = 4'hf;
    logic [31:0] DAT_I = 32'h00000000;
    logic DATA_IN = 1'b0;
    logic [7:0] SHUTDOWN_SRC = 8'h00;
    logic [31:0] DAT_O;
    logic ACK_O, OUT_A, OUT_B, OUT_C, OUT_D;
    logic OUT_A_OE_N, OUT_B_OE_N, OUT_C_OE_N, OUT_D_OE_N;
    logic [3:0] gate;
    logic [31:0] q;
    logic [1:0] ac, bd;
    int n_fail = 0;
    int checked = 0;
    int r0, f0, r1, f1, t0;

    // ----------------------------------------------------------------
    // clock, design and gate drivers
    // ----------------------------------------------------------------
    // 250 MHz clock
    always #2 CLOCK = ~CLOCK;

    cwgsd_top dut (.CLOCK(CLOCK), .RSTN(RSTN), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I),
        .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O),
        .DATA_IN(DATA_IN), .SHUTDOWN_SRC(SHUTDOWN_SRC), .OUT_A(OUT_A), .OUT_B(OUT_B),
        .OUT_C(OUT_C), .OUT_D(OUT_D), .OUT_A_OE_N(OUT_A_OE_N), .OUT_B_OE_N(OUT_B_OE_N),
        .OUT_C_OE_N(OUT_C_OE_N), .OUT_D_OE_N(OUT_D_OE_N));

    cwgsd_gate_model drivers (.drive({OUT_D, OUT_C, OUT_B, OUT_A}),
        .oe_n({OUT_D_OE_N, OUT_C_OE_N, OUT_B_OE_N, OUT_A_OE_N}), .gate(gate));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic report_and_stop;
        $display("comparisons %0d, mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : report_and_stop

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // one classic wishbone cycle, held until ack is sampled high
    task automatic wb(input logic we, input logic [11:0] idx, input logic [7:0] wd);
        int i;
        @(posedge CLOCK);
        CYC_I <= 1'b1;
        STB_I <= 1'b1;
        WE_I <= we;
        SEL_I <= 4'hf;
        ADR_I <= {idx, 2'b00};
        DAT_I <= {24'h000000, wd};
        for (i = 0; i < 50; i++) begin
            @(posedge CLOCK);
            if (ACK_O === 1'b1) break;
        end
        q = DAT_O;
        CYC_I <= 1'b0;
        STB_I <= 1'b0;
        if (i == 50) begin
            n_fail++;
            report_and_stop();
        end
    endtask : wb

    task automatic wr(input logic [11:0] idx, input logic [7:0] wd);
        wb(1'b1, idx, wd);
    endtask : wr

    task automatic rdchk(input logic [11:0] idx, input logic [31:0] exp);
        wb(1'b0, idx, 8'h00);
        check(q, exp);
    endtask : rdchk

    // drive the data input and count edges until the watched pin goes high
    task automatic lat(input logic lvl, input logic use_b, output int c);
        @(posedge CLOCK);
        DATA_IN <= lvl;
        for (c = 0; c < 200; c++) begin
            @(posedge CLOCK);
            #1;
            if ((use_b ? OUT_B : OUT_A) === 1'b1) break;
        end
        if (c == 200) begin
            n_fail++;
            report_and_stop();
        end
    endtask : lat

    // program both counts while disabled, enable, then time one rise and one fall
    task automatic run_db(input logic [7:0] dr, input logic [7:0] df, output int r, output int f);
        wr(RIDX_GEN_CTRL, 8'h00);
        wr(RIDX_DB_RISE, dr);
        wr(RIDX_DB_FALL, df);
        wr(RIDX_GEN_CTRL, 8'h80);
        repeat (70) @(posedge CLOCK);
        lat(1'b1, 1'b0, r);
        repeat (4) @(posedge CLOCK);
        lat(1'b0, 1'b1, f);
        repeat (10) @(posedge CLOCK);
    endtask : run_db

    // expected {oe_n, gate level} of a pin in shutdown, polarity bit set
    function automatic logic [1:0] sd_exp(input logic [1:0] c);
        return (c == 2'b01) ? 2'b10 : (c == 2'b10 ? 2'b00 : 2'b01);
    endfunction : sd_exp

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (16) @(posedge CLOCK);
        RSTN <= 1'b1;
        rdchk(RIDX_SD_CTRL, {24'h0, SD_CTRL_RST});
        rdchk(RIDX_SD_SRC, {24'h0, SD_SRC_RST});
        rdchk(12'h3c4, 32'h0);
        check({OUT_A_OE_N, OUT_B_OE_N, OUT_C_OE_N, OUT_D_OE_N}, 32'hf);
        wr(RIDX_DB_RISE, 8'hff);
        rdchk(RIDX_DB_RISE, 32'h3f);
        run_db(8'h00, 8'h00, r0, f0);
        run_db(8'h03, 8'h05, r1, f1);
        check(r1 - r0, 3);
        check(f1 - f0, 5);
        check(r0, 0);
        check(f0, 0);
        // new rising count without load stays unused, with load waits for a fall
        wr(RIDX_DB_RISE, 8'h00);
        lat(1'b1, 1'b0, t0);
        check(t0, r1);
        lat(1'b0, 1'b1, t0);
        wr(RIDX_GEN_CTRL, 8'hc0);
        lat(1'b1, 1'b0, t0);
        check(t0, r1);
        lat(1'b0, 1'b1, t0);
        repeat (10) @(posedge CLOCK);
        lat(1'b1, 1'b0, t0);
        check(t0, r0);
        wb(1'b0, RIDX_GEN_CTRL, 8'h00);
        check(q[6], 1'b0);
        // polarity inverts both pairs while data is high
        wr(RIDX_POL_CTRL, 8'h0f);
        repeat (3) @(posedge CLOCK);
        #1;
        check({OUT_A, OUT_B, OUT_C, OUT_D}, 32'h5);
        rdchk(RIDX_POL_CTRL, 32'h2f);
        // every state code on both pairs, each source bit, manual clear and restart
        for (int k = 0; k < 4; k++) begin
            bd = 2'(k);
            ac = 2'(3 - k);
            wr(RIDX_SD_SRC, 8'hff);
            wr(RIDX_SD_CTRL, {2'b00, bd, ac, 2'b00});
            @(posedge CLOCK);
            SHUTDOWN_SRC <= 8'h03 << (2 * k);
            repeat (3) @(posedge CLOCK);
            #1;
            check({OUT_A_OE_N, gate[0], OUT_C_OE_N, gate[2]}, {sd_exp(ac), sd_exp(ac)});
            check({OUT_B_OE_N, gate[1], OUT_D_OE_N, gate[3]}, {sd_exp(bd), sd_exp(bd)});
            @(posedge CLOCK);
            SHUTDOWN_SRC <= 8'h00;
            repeat (3) @(posedge CLOCK);
            rdchk(RIDX_SD_CTRL, {24'h0, 2'b10, bd, ac, 2'b00});
            wr(RIDX_SD_CTRL, {2'b00, bd, ac, 2'b00});
            rdchk(RIDX_SD_CTRL, {24'h0, 2'b00, bd, ac, 2'b00});
            DATA_IN <= 1'b0;
            repeat (4) @(posedge CLOCK);
            #1;
            check({OUT_A_OE_N, gate[0]}, sd_exp(ac));
            @(posedge CLOCK);
            DATA_IN <= 1'b1;
            repeat (4) @(posedge CLOCK);
            #1;
            check({OUT_A_OE_N, OUT_A}, 32'h0);
        end
        // a source whose enable is off is ignored
        wr(RIDX_SD_SRC, 8'h7f);
        SHUTDOWN_SRC <= 8'h80;
        repeat (3) @(posedge CLOCK);
        rdchk(RIDX_SD_CTRL, 32'h30);
        SHUTDOWN_SRC <= 8'h00;
        // auto-restart clears the status once the cause is gone
        wr(RIDX_SD_CTRL, 8'h70);
        SHUTDOWN_SRC <= 8'h01;
        repeat (3) @(posedge CLOCK);
        rdchk(RIDX_SD_CTRL, 32'hf0);
        SHUTDOWN_SRC <= 8'h00;
        repeat (3) @(posedge CLOCK);
        rdchk(RIDX_SD_CTRL, 32'h70);
        // software forces shutdown while disabled
        wr(RIDX_GEN_CTRL, 8'h00);
        wr(RIDX_SD_CTRL, 8'hbc);
        repeat (3) @(posedge CLOCK);
        #1;
        check({OUT_A_OE_N, OUT_A, OUT_D_OE_N, OUT_D}, 32'h5);
        rdchk(RIDX_SD_CTRL, 32'hbc);
        // a mid-run reset keeps both counts and leaves the pins undriven
        RSTN <= 1'b0;
        repeat (2) @(posedge CLOCK);
        RSTN <= 1'b1;
        rdchk(RIDX_DB_RISE, 32'h0);
        rdchk(RIDX_DB_FALL, 32'h5);
        check({OUT_A_OE_N, OUT_B_OE_N, OUT_C_OE_N, OUT_D_OE_N}, 32'hf);
        report_and_stop();
    end
endmodule : tb
